/* File: hdl/odd_timer_pkg.sv */
// Purpose: Constants for the odd timer control block.
// Assumes: One 16-bit control register reached over a plain strobe port.
// Notes:   Bit positions and encodings of the control register.
package odd_timer_pkg;
    localparam logic [3:0]  ctrl_addr          = 4'h0;
    localparam logic [3:0]  count_addr         = 4'h1;
    localparam int          run_bit            = 15;
    localparam int          idle_bit           = 13;
    localparam int          ext_hi_bit         = 9;
    localparam int          ext_lo_bit         = 8;
    localparam int          gate_bit           = 6;
    localparam int          pre_hi_bit         = 5;
    localparam int          pre_lo_bit         = 4;
    localparam int          src_bit            = 1;
    localparam logic [15:0] ctrl_write_mask    = 16'ha372;
    localparam logic [15:0] ctrl_reset         = 16'h0000;
    localparam logic [1:0]  ext_timer_input    = 2'h3;
    localparam logic [1:0]  ext_low_power_rc_oscillator           = 2'h2;
    localparam logic [1:0]  ext_clock_pin      = 2'h1;
    localparam logic [1:0]  ext_secondary      = 2'h0;
    localparam logic [1:0]  pre_div256         = 2'h3;
    localparam logic [1:0]  pre_div64          = 2'h2;
    localparam logic [1:0]  pre_div8           = 2'h1;
    localparam logic [7:0]  pre_last_256       = 8'hff;
    localparam logic [7:0]  pre_last_64        = 8'h3f;
    localparam logic [7:0]  pre_last_8         = 8'h07;
    localparam logic [7:0]  pre_last_1         = 8'h00;
endpackage

/* File: hdl/odd_timer_control.sv */
// Purpose: Control logic of the odd timer of a pair: run, idle stop, source, gate, prescale.
// Assumes: All inputs synchronous to clk; internal tick is one-cycle pulse at Fosc/2.
// Notes:   In paired mode this timer's own control bits are bypassed; even timer rules.
`timescale 1ns/100ps
module odd_timer_control (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Register port
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // Count sources
    input  wire logic        internal_tick,
    input  wire logic        generic_timer_input,
    input  wire logic        low_power_rc_oscillator,
    input  wire logic        external_clock_pin,
    input  wire logic        secondary_oscillator,
    input  wire logic        gate_in,
    // System state
    input  wire logic        cpu_idle,
    input  wire logic        pair_32bit,
    // Timer outputs
    output logic             count_tick,
    output logic      [15:0] count
);
    // Control register state.
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    // Prescaler and counter state.
    logic [7:0]  pre_cnt;
    logic [7:0]  next_pre_cnt;
    logic [15:0] next_count;
    logic        next_count_tick;
    // Edge history of the selected source and of the gate.
    logic        ext_prev;
    logic        next_ext_prev;
    logic        gate_prev;
    logic        next_gate_prev;
    // Read data state.
    logic [15:0] next_rdata;
    // Decoded strobes and qualified events.
    logic        ctrl_write;
    logic        count_write;
    logic        ext_level;
    logic        src_event;
    logic        gate_fall;
    logic        active;
    logic [7:0]  pre_last;

    // Register port decode, shared by the control and the count groups.
    always_comb begin
        ctrl_write  = wr && (addr == odd_timer_pkg::ctrl_addr);
        count_write = wr && (addr == odd_timer_pkg::count_addr);
    end

    // Source selection, prescale limit and run qualification.
    always_comb begin
        case (ctrl[odd_timer_pkg::ext_hi_bit:odd_timer_pkg::ext_lo_bit])
            odd_timer_pkg::ext_timer_input: ext_level = generic_timer_input;
            odd_timer_pkg::ext_low_power_rc_oscillator:        ext_level = low_power_rc_oscillator;
            odd_timer_pkg::ext_clock_pin:   ext_level = external_clock_pin;
            default:                        ext_level = secondary_oscillator;
        endcase
        case (ctrl[odd_timer_pkg::pre_hi_bit:odd_timer_pkg::pre_lo_bit])
            odd_timer_pkg::pre_div256: pre_last = odd_timer_pkg::pre_last_256;
            odd_timer_pkg::pre_div64:  pre_last = odd_timer_pkg::pre_last_64;
            odd_timer_pkg::pre_div8:   pre_last = odd_timer_pkg::pre_last_8;
            default:                   pre_last = odd_timer_pkg::pre_last_1;
        endcase
        // Gating only applies to the internal tick; external edges ignore it.
        if (ctrl[odd_timer_pkg::src_bit]) begin
            src_event = ext_level && !ext_prev;
        end else if (ctrl[odd_timer_pkg::gate_bit]) begin
            src_event = internal_tick && gate_in;
        end else begin
            src_event = internal_tick;
        end
        // Pairing overrides every local bit, so the even timer alone decides.
        active = ctrl[odd_timer_pkg::run_bit]
                 && !(cpu_idle && ctrl[odd_timer_pkg::idle_bit])
                 && !pair_32bit;
        // Gated mode pulses count_tick as the gate falls, without adding to the count.
        gate_fall = active
                    && !ctrl[odd_timer_pkg::src_bit]
                    && ctrl[odd_timer_pkg::gate_bit]
                    && gate_prev
                    && !gate_in;
    end

    // Control register: only implemented bits are stored, so the rest read zero.
    always_comb begin
        next_ctrl = ctrl;
        if (ctrl_write) begin
            next_ctrl = wdata & odd_timer_pkg::ctrl_write_mask;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= odd_timer_pkg::ctrl_reset;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // Edge history. The source history follows the selected input even while
    // stopped, so a level already high at start is not taken as a fresh edge.
    always_comb begin
        next_ext_prev  = ext_level;
        next_gate_prev = gate_in;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_prev  <= 1'b0;
            gate_prev <= 1'b0;
        end else begin
            ext_prev  <= next_ext_prev;
            gate_prev <= next_gate_prev;
        end
    end

    // Prescaler and counter. A control write wins over a source event in the
    // same cycle only in the prescaler, which restarts from zero after such a write if the run bit was already set; a terminal event still counts.
    always_comb begin
        next_pre_cnt    = pre_cnt;
        next_count      = count;
        next_count_tick = 1'b0;
        if (active && src_event) begin
            if (pre_cnt >= pre_last) begin
                next_pre_cnt    = 8'h00;
                next_count      = count + 16'h0001;
                next_count_tick = 1'b1;
            end else begin
                next_pre_cnt = pre_cnt + 8'h01;
            end
        end
        if (gate_fall) begin
            next_count_tick = 1'b1;
        end
        if (ctrl_write && ctrl[odd_timer_pkg::run_bit]) begin
            next_pre_cnt = 8'h00;
        end
        // A count write leaves the prescaler alone; of the writes, only a control write made while the run bit is set clears it.
        if (count_write) begin
            next_count = wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_cnt    <= 8'h00;
            count      <= 16'h0000;
            count_tick <= 1'b0;
        end else begin
            pre_cnt    <= next_pre_cnt;
            count      <= next_count;
            count_tick <= next_count_tick;
        end
    end

    // Read data stand for one cycle after the strobe and are zero otherwise.
    always_comb begin
        next_rdata = 16'h0000;
        if (rd) begin
            case (addr)
                odd_timer_pkg::ctrl_addr:  next_rdata = ctrl;
                odd_timer_pkg::count_addr: next_rdata = count;
                default:                   next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Limitation: external inputs are sampled on clk, so a source must stay
    // high and low for at least one clock each to be counted once.

    // Limitation: the gate is also taken as synchronous; a gate pulse shorter
    // than one clock can be lost entirely.

endmodule // odd_timer_control

/* File: tb/odd_timer_asserts.sv */
// Purpose: Port assertions for the odd timer control.
// Assumes: One clock domain, reset async active low.
// Notes:   Attached by the bind below.
`timescale 1ns/100ps
module odd_timer_asserts (
    // Clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // Register port
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    // Timer
    input wire logic        pair_32bit,
    input wire logic        count_tick,
    input wire logic [15:0] count
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_wr_rd; wr && addr == 4'h0 ##1 rd && addr == 4'h0; endsequence
    property p_back; s_wr_rd |=> rdata == ($past(wdata, 2) & 16'ha372); endproperty
    a_back: assert property (p_back) else $error("control readback wrong");
    property p_mask; rd && addr == 4'h0 |=> (rdata & 16'h5c8d) == 16'h0000; endproperty
    a_mask: assert property (p_mask) else $error("unimplemented bit set");
    property p_idle; !rd |=> rdata == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_unmap; rd && addr > 4'h1 |=> rdata == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_cnt_rd; rd && addr == 4'h1 |=> rdata == $past(count); endproperty
    a_cnt_rd: assert property (p_cnt_rd) else $error("count read wrong");
    property p_hold; !count_tick && !$past(wr) |-> $stable(count); endproperty
    a_hold: assert property (p_hold) else $error("count moved without tick");
    property p_step; count_tick && !$past(wr) |-> count - $past(count) <= 16'h0001; endproperty
    a_step: assert property (p_step) else $error("count step too large");
    property p_pair; pair_32bit && $past(pair_32bit) |-> !count_tick; endproperty
    a_pair: assert property (p_pair) else $error("tick while paired");
endmodule // odd_timer_asserts
bind odd_timer_control odd_timer_asserts u_chk (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pair_32bit(pair_32bit),
    .count_tick(count_tick), .count(count));

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the odd timer control.
// Assumes: 40 MHz clock; gate and idle inputs held low except in t_gate and t_idle.
// Notes:   Count is read back over the register port.
`timescale 1ns/100ps
module tb_top;
    logic        clk = 0, arst_n = 0, wr = 0, rd = 0, tck = 0, pair = 0;
    logic        gate = 0, idle = 0, tk;
    logic [3:0]  addr = 4'h0, src = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, count;
    int          n_errors = 0, total_checks = 0, d[3] = '{8, 64, 256};
    always #12.5 clk = ~clk;
    odd_timer_control u_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .internal_tick(tck), .generic_timer_input(src[3]),
        .low_power_rc_oscillator(src[2]), .external_clock_pin(src[1]),
        .secondary_oscillator(src[0]), .gate_in(gate), .cpu_idle(idle),
        .pair_32bit(pair), .count_tick(tk), .count(count));
    task check(logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task wreg(logic [3:0] a, logic [15:0] v);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk) wr <= 1'b0;
        @(posedge clk);
    endtask
    task wrd(logic [15:0] v, logic [15:0] e);
        wr <= 1'b1; addr <= 4'h0; wdata <= v;
        @(posedge clk) wr <= 1'b0; rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        #1 check(rdata, e);
        @(posedge clk);
    endtask
    task rchk(logic [3:0] a, logic [15:0] e);
        rd <= 1'b1; addr <= a;
        @(posedge clk) rd <= 1'b0;
        #1 check(rdata, e);
        @(posedge clk);
    endtask
    // Each event is one high cycle then one low cycle, so every pulse is a fresh rising edge.
    task ev(int n, logic [3:0] s, logic t);
        repeat (n) begin
            src <= s; tck <= t;
            @(posedge clk) src <= 4'h0; tck <= 1'b0;
            @(posedge clk);
        end
    endtask
    task t_reg;
        wrd(16'hffff, 16'ha372);
        rchk(4'h7, 16'h0000); wreg(4'h0, 16'h0000);
    endtask
    task t_run;
        wreg(4'h1, 16'h0000); wreg(4'h0, 16'h8000); ev(3, 4'h0, 1'b1);
        rchk(4'h1, 16'h0003); wreg(4'h0, 16'h0000); ev(3, 4'h0, 1'b1);
        rchk(4'h1, 16'h0003);
    endtask
    task t_pre;
        for (int p = 1; p < 4; p++) begin
            wreg(4'h1, 16'h0000); wreg(4'h0, {10'h200, p[1:0], 4'h0}); ev(d[p-1] - 1, 4'h0, 1'b1);
            wreg(4'h0, {10'h200, p[1:0], 4'h0}); ev(d[p-1] - 1, 4'h0, 1'b1);
            rchk(4'h1, 16'h0000); ev(1, 4'h0, 1'b1);
            rchk(4'h1, 16'h0001);
        end
    endtask
    task t_ext;
        for (int e = 0; e < 4; e++) begin
            wreg(4'h0, {6'h20, e[1:0], 8'h02}); wreg(4'h1, 16'h0000);
            ev(2, ~(4'h1 << e), 1'b1); ev(3, 4'h1 << e, 1'b0);
            rchk(4'h1, 16'h0003);
        end
    endtask
    task t_gate;
        wreg(4'h0, 16'h8040); wreg(4'h1, 16'h0000); gate <= 1'b1;
        ev(3, 4'h0, 1'b1); gate <= 1'b0;
        @(posedge clk) #1 check(tk, 1'b1);
        @(posedge clk) #1 check(tk, 1'b0);
        @(posedge clk);
        ev(2, 4'h0, 1'b1); rchk(4'h1, 16'h0003);
        wreg(4'h0, 16'h8042); wreg(4'h1, 16'h0000); ev(2, 4'h1, 1'b1);
        rchk(4'h1, 16'h0002);
    endtask
    task t_idle;
        wreg(4'h0, 16'ha000); wreg(4'h1, 16'h0000); idle <= 1'b1;
        ev(2, 4'h0, 1'b1); rchk(4'h1, 16'h0000);
        idle <= 1'b0; ev(2, 4'h0, 1'b1); rchk(4'h1, 16'h0002);
        wreg(4'h0, 16'h8000); idle <= 1'b1; ev(2, 4'h0, 1'b1);
        rchk(4'h1, 16'h0004); idle <= 1'b0;
    endtask
    task t_pair;
        wreg(4'h0, 16'h0000); wreg(4'h1, 16'h0000); pair <= 1'b1;
        wreg(4'h0, 16'h8000); ev(3, 4'h0, 1'b1);
        rchk(4'h1, 16'h0000); pair <= 1'b0;
    endtask
    task results;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reg; t_run; t_pre; t_ext; t_gate; t_idle; t_pair;
        results;
    end
    initial begin
        #200us n_errors++;
        results;
    end
endmodule // tb_top
